// >>> design/mmc_pkg.sv
package mmc_pkg;
    localparam logic [7:0]  OP_EVENT_REQ    = 8'h8A;
    localparam logic [7:0]  OP_STOP_APP     = 8'h80;
    localparam logic [7:0]  OP_RUN_APP      = 8'h81;
    localparam logic [7:0]  OP_STEP_APP     = 8'h82;
    localparam logic [7:0]  OP_RESET_APP    = 8'h83;
    localparam logic [7:0]  OP_ENTER_DL     = 8'h84;
    localparam logic [7:0]  OP_EXIT_DL      = 8'h85;
    localparam logic [7:0]  OP_READ_MEM     = 8'h86;
    localparam logic [7:0]  OP_GET_STATUS   = 8'h87;
    localparam logic [7:0]  OP_GET_VERSION  = 8'h88;
    localparam logic [7:0]  OP_FACTORY      = 8'h89;
    localparam logic [7:0]  OP_SW_RESET     = 8'hFF;
    localparam logic [7:0]  OP_MOVE_TO_POS  = 8'h04;
    localparam logic [7:0]  ST_OK           = 8'h64;
    localparam logic [7:0]  ST_POS_REACHED  = 8'h80;
    localparam logic [7:0]  ST_SPECIAL      = 8'h64;
    localparam logic [31:0] MAGIC_KEY       = 32'h0000_04D2;
    localparam logic [7:0]  TYPE_ONCE       = 8'h00;
    localparam logic [7:0]  TYPE_PERSIST    = 8'h01;
    localparam logic [31:0] VERSION_BIN     = 32'h0000_0001; // arbitrary value
    localparam logic [31:0] VERSION_STR     = 32'h0000_0031; // arbitrary value
    localparam int          PC_W            = 10;
    localparam int          MEM_DEPTH       = 1024;
    localparam logic [PC_W-1:0] PC_RST      = 10'h000;
    localparam logic [7:0]  MODE_IDLE       = 8'h00;
    localparam logic [7:0]  MODE_RUN        = 8'h01;
    localparam logic [7:0]  MODE_STEP       = 8'h02;
    localparam logic [7:0]  MODE_DL         = 8'h03;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  ctype;
        logic [7:0]  bank;
        logic [31:0] value;
        logic        direct;
    } mmc_cmd_t;

    typedef struct packed {
        logic [7:0]  status;
        logic [7:0]  command;
        logic [31:0] value;
    } mmc_reply_t;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  ctype;
        logic [7:0]  bank;
        logic [31:0] value;
    } mmc_instr_t;
endpackage

// >>> design/mmc_checksum.sv
`timescale 1ns/1ps
module mmc_checksum
(
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_host,
    input  wire logic [7:0]  i_status,
    input  wire logic [7:0]  i_command,
    input  wire logic [31:0] i_value,
    output logic      [7:0]  o_sum
);
    // sum over all frame bytes, mask byte included
    always_comb
    begin
        o_sum = i_addr + i_host + i_status + i_command
              + i_value[31:24] + i_value[23:16] + i_value[15:8] + i_value[7:0];
    end
endmodule

// >>> design/mmc_prog_mem.sv
`timescale 1ns/1ps
module mmc_prog_mem
    import mmc_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_we,
    input  wire logic [PC_W-1:0]  i_waddr,
    input  wire mmc_pkg::mmc_instr_t i_wdata,
    input  wire logic [PC_W-1:0]  i_raddr,
    output mmc_pkg::mmc_instr_t   o_rdata
);
    mmc_instr_t mem [MEM_DEPTH];

    always_ff @(posedge i_clk)
    begin
        if (i_we)
        begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule

// >>> design/mmc_ctrl.sv
// Functional notes
// R1: event request gives an immediate reply and a later position-reached reply.
// R2: event request accepted only from direct mode, not from stored program.
// R3: value is a motor mask; only bit 0 matters, host sends 1.
// R4: type 0 arms position-reached reply for the next move only.
// R5: type 1 arms position-reached reply for every following move.
// R6: immediate reply status 100, command 138, upper value bytes zero.
// R7: later reply status 128, command 138, upper value bytes zero.
// R8: both replies echo mask in byte 0; checksum covers it.
// R9: control commands honoured only in direct mode.
// R10: host sets motor/bank field to zero in control commands.
// R11: opcode 128 halts the running program; type and value ignored.
// R12: opcode 129 runs; type 0 from current, type 1 from value address.
// R13: opcode 130 executes exactly one more instruction then stops.
// R14: opcode 131 stops, clears pc, sp, accumulator, x and flags.
// R15: opcode 132 enters download at value address; commands stored instead.
// R16: opcode 133 leaves download mode; commands execute again.
// R17: opcode 134 returns program memory word at value address.
// R18: opcode 135 reports status by type 0..3.
// R19: opcode 136 returns version, string type 0, binary type 1.
// R20: opcode 137 restores factory defaults with key 1234, no reply.
// R21: opcode 255 with key 1234 restarts module; reply may be lost.
// R22: one-shot request disarms after its reply; persistent stays until replaced.
`timescale 1ns/1ps
module mmc_ctrl
    import mmc_pkg::*;
(
    input  wire logic                i_clk,
    input  wire logic                i_rstn,
    input  wire logic                i_cmd_valid,
    input  wire mmc_pkg::mmc_cmd_t   i_cmd,
    input  wire logic                i_pos_reached,
    input  wire logic                i_prog_done,
    input  wire logic [31:0]         i_accu,
    input  wire logic [31:0]         i_xreg,
    input  wire logic                i_wait_flag,
    output logic                     o_reply_valid,
    output mmc_pkg::mmc_reply_t      o_reply,
    output logic [7:0]               o_reply_sum,
    output logic                     o_exec_valid,
    output mmc_pkg::mmc_instr_t      o_exec,
    output logic                     o_prog_run,
    output logic                     o_prog_step,
    output logic [PC_W-1:0]          o_pc,
    output logic                     o_prog_clear,
    output logic                     o_factory,
    output logic                     o_sw_reset,
    output logic                     o_dl_mode
);
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_STEP = 2'b11
    } mmc_pstate_t;

    mmc_pstate_t     pstate_q;
    logic            armed_q;
    logic            persist_q;
    logic [7:0]      mask_q;
    logic            move_pend_q;
    logic            dl_q;
    logic [PC_W-1:0] dl_ptr_q;
    logic [PC_W-1:0] pc_q;
    logic            rd_pend_q;
    logic            is_ctrl;
    logic            ctl_ok;
    logic            is_move;
    logic            dl_store;
    logic            pos_evt;
    mmc_instr_t      mem_rdata;
    mmc_instr_t      cmd_instr;
    mmc_reply_t      reply_d;
    logic            reply_v_d;
    logic [7:0]      sum_d;

    assign cmd_instr = '{opcode: i_cmd.opcode, ctype: i_cmd.ctype,
                         bank: i_cmd.bank, value: i_cmd.value};
    assign is_ctrl   = (i_cmd.opcode >= OP_STOP_APP && i_cmd.opcode <= OP_EVENT_REQ)
                     || (i_cmd.opcode == OP_SW_RESET);
    assign ctl_ok    = i_cmd_valid && i_cmd.direct && is_ctrl; // [R9] [R2]
    assign dl_store  = i_cmd_valid && i_cmd.direct && !is_ctrl && dl_q; // [R15]
    assign is_move   = i_cmd_valid && !is_ctrl && !dl_q && i_cmd.opcode == OP_MOVE_TO_POS;
    assign pos_evt   = move_pend_q && i_pos_reached;

    mmc_prog_mem u_mem
    (
        .i_clk   (i_clk),
        .i_we    (dl_store),
        .i_waddr (dl_ptr_q),
        .i_wdata (cmd_instr),
        .i_raddr (i_cmd.value[PC_W-1:0]),
        .o_rdata (mem_rdata)
    );

    mmc_checksum u_sum
    (
        .i_addr    (8'h01),
        .i_host    (8'h02),
        .i_status  (reply_d.status),
        .i_command (reply_d.command),
        .i_value   (reply_d.value),
        .o_sum     (sum_d)
    );

    // program state
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            pstate_q <= ST_IDLE;
            pc_q     <= PC_RST;
        end
        else if (ctl_ok && (i_cmd.opcode == OP_STOP_APP))
        begin
            pstate_q <= ST_IDLE; // [R11]
        end
        else if (ctl_ok && (i_cmd.opcode == OP_RESET_APP))
        begin
            pstate_q <= ST_IDLE; // [R14]
            pc_q     <= PC_RST;
        end
        else if (ctl_ok && (i_cmd.opcode == OP_RUN_APP))
        begin
            pstate_q <= ST_RUN; // [R12]
            if (i_cmd.ctype == TYPE_PERSIST)
            begin
                pc_q <= i_cmd.value[PC_W-1:0];
            end
        end
        else if (ctl_ok && (i_cmd.opcode == OP_STEP_APP))
        begin
            pstate_q <= ST_STEP; // [R13]
        end
        else if (i_prog_done && pstate_q != ST_IDLE)
        begin
            pc_q <= pc_q + 10'h001;
            if (pstate_q == ST_STEP)
            begin
                pstate_q <= ST_IDLE; // [R13]
            end
        end
    end

    // download mode
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            dl_q     <= 1'b0;
            dl_ptr_q <= PC_RST;
        end
        else if (ctl_ok && i_cmd.opcode == OP_ENTER_DL)
        begin
            dl_q     <= 1'b1; // [R15]
            dl_ptr_q <= i_cmd.value[PC_W-1:0];
        end
        else if (ctl_ok && i_cmd.opcode == OP_EXIT_DL)
        begin
            dl_q <= 1'b0; // [R16]
        end
        else if (dl_store)
        begin
            dl_ptr_q <= dl_ptr_q + 10'h001;
        end
    end

    // position-reached event arming
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            armed_q     <= 1'b0;
            persist_q   <= 1'b0;
            mask_q      <= 8'h00;
            move_pend_q <= 1'b0;
        end
        else
        begin
            if (ctl_ok && i_cmd.opcode == OP_EVENT_REQ)
            begin
                armed_q   <= 1'b1; // [R1]
                persist_q <= (i_cmd.ctype == TYPE_PERSIST); // [R4] [R5]
                mask_q    <= i_cmd.value[7:0]; // [R3]
            end
            else if (pos_evt && !persist_q)
            begin
                armed_q <= 1'b0; // [R22]
            end
            if (is_move && armed_q)
            begin
                move_pend_q <= 1'b1;
            end
            else if (i_pos_reached)
            begin
                move_pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            rd_pend_q <= 1'b0;
        end
        else
        begin
            rd_pend_q <= ctl_ok && i_cmd.opcode == OP_READ_MEM;
        end
    end

    // reply selection
    always_comb
    begin
        reply_v_d = 1'b0;
        reply_d   = '{status: ST_OK, command: i_cmd.opcode, value: 32'h0000_0000};
        if (rd_pend_q)
        begin
            reply_v_d = 1'b1; // [R17]
            reply_d   = '{status: ST_SPECIAL, command: OP_READ_MEM,
                          value: {mem_rdata.opcode, mem_rdata.ctype,
                                  mem_rdata.bank, mem_rdata.value[7:0]}};
        end
        else if (pos_evt && armed_q)
        begin
            reply_v_d = 1'b1; // [R7] [R8]
            reply_d   = '{status: ST_POS_REACHED, command: OP_EVENT_REQ,
                          value: {24'h00_0000, mask_q}};
        end
        else if (ctl_ok)
        begin
            reply_v_d = 1'b1;
            unique case (i_cmd.opcode)
                OP_EVENT_REQ:
                begin
                    reply_d.value = {24'h00_0000, i_cmd.value[7:0]}; // [R6] [R8]
                end
                OP_READ_MEM:
                begin
                    reply_v_d = 1'b0;
                end
                OP_GET_STATUS:
                begin
                    unique case (i_cmd.ctype[1:0]) // [R18]
                        2'd0: reply_d.value = {dl_q ? MODE_DL : MODE_IDLE,
                                               7'h00, i_wait_flag,
                                               6'h00, dl_ptr_q};
                        2'd1: reply_d.value = {pstate_q == ST_RUN ? MODE_RUN : MODE_IDLE,
                                               7'h00, i_wait_flag, 6'h00, pc_q};
                        2'd2: reply_d.value = i_accu;
                        2'd3: reply_d.value = i_xreg;
                    endcase
                end
                OP_GET_VERSION:
                begin
                    reply_d.value = (i_cmd.ctype == TYPE_ONCE) ? VERSION_STR
                                                               : VERSION_BIN; // [R19]
                end
                OP_FACTORY:
                begin
                    reply_v_d = 1'b0; // [R20]
                end
                default:
                begin
                    reply_d.value = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            o_reply_valid <= 1'b0;
            o_reply       <= '0;
            o_reply_sum   <= 8'h00;
        end
        else
        begin
            o_reply_valid <= reply_v_d;
            o_reply       <= reply_d;
            o_reply_sum   <= sum_d; // [R8]
        end
    end

    // side effects
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            o_exec_valid <= 1'b0;
            o_exec       <= '0;
            o_prog_clear <= 1'b0;
            o_factory    <= 1'b0;
            o_sw_reset   <= 1'b0;
        end
        else
        begin
            o_exec_valid <= i_cmd_valid && !is_ctrl && !dl_q; // [R16]
            o_exec       <= cmd_instr;
            o_prog_clear <= ctl_ok && i_cmd.opcode == OP_RESET_APP; // [R14]
            o_factory    <= ctl_ok && i_cmd.opcode == OP_FACTORY
                            && i_cmd.value == MAGIC_KEY; // [R20]
            o_sw_reset   <= ctl_ok && i_cmd.opcode == OP_SW_RESET
                            && i_cmd.value == MAGIC_KEY; // [R21]
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            o_prog_run  <= 1'b0;
            o_prog_step <= 1'b0;
            o_pc        <= PC_RST;
            o_dl_mode   <= 1'b0;
        end
        else
        begin
            o_prog_run  <= (pstate_q != ST_IDLE);
            o_prog_step <= (pstate_q == ST_STEP);
            o_pc        <= pc_q;
            o_dl_mode   <= dl_q;
        end
    end

    a_event_reply: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R6]
        ctl_ok && i_cmd.opcode == OP_EVENT_REQ && !rd_pend_q && !(pos_evt && armed_q)
        |=> o_reply_valid && o_reply.status == ST_OK && o_reply.command == OP_EVENT_REQ
        && o_reply.value[31:8] == 24'h00_0000 && o_reply.value[7:0] == $past(i_cmd.value[7:0]))
        else $error("event request immediate reply wrong");
    a_pos_reply: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R7]
        pos_evt && armed_q && !rd_pend_q |=> o_reply_valid
        && o_reply.status == ST_POS_REACHED && o_reply.value[7:0] == $past(mask_q))
        else $error("position reached reply wrong");
    a_oneshot_clear: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R22]
        pos_evt && !persist_q && !ctl_ok |=> !armed_q)
        else $error("one-shot request stayed armed");
    a_persist_keep: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R5]
        armed_q && persist_q && !ctl_ok |=> armed_q)
        else $error("persistent request lost");
    a_no_prog_ctrl: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R9]
        i_cmd_valid && !i_cmd.direct && is_ctrl && !rd_pend_q && !pos_evt
        |=> !o_reply_valid)
        else $error("control command from program honoured");
    a_stop_halts: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R11]
        ctl_ok && i_cmd.opcode == OP_STOP_APP |=> ##1 !o_prog_run)
        else $error("stop did not halt");
    a_step_once: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R13]
        pstate_q == ST_STEP && i_prog_done && !ctl_ok |=> pstate_q == ST_IDLE)
        else $error("step ran past one instruction");
    a_factory_key: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R20]
        o_factory |-> $past(i_cmd.value) == MAGIC_KEY
        && !(o_reply_valid && o_reply.command == OP_FACTORY))
        else $error("factory restore without key or with reply");
    a_dl_no_exec: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R15]
        dl_store |=> !o_exec_valid)
        else $error("command executed in download mode");
    c_event_pair: cover property (@(posedge i_clk) disable iff (!i_rstn)
        ctl_ok && i_cmd.opcode == OP_EVENT_REQ ##[1:50] pos_evt);
    c_download: cover property (@(posedge i_clk) disable iff (!i_rstn)
        dl_store ##[1:20] ctl_ok && i_cmd.opcode == OP_EXIT_DL);
    c_step: cover property (@(posedge i_clk) disable iff (!i_rstn)
        pstate_q == ST_STEP ##1 pstate_q == ST_IDLE);
endmodule

// >>> sim/mmc_host_model.sv
`timescale 1ns/1ps
module mmc_host_model
    import mmc_pkg::*;
(
    input  wire logic          i_clk,
    output logic               o_cmd_valid,
    output mmc_pkg::mmc_cmd_t  o_cmd
);
    import mmc_pkg::*;

    initial
    begin
        o_cmd_valid = 1'b0;
        o_cmd       = '0;
    end

    // one frame; released fields flip so stale data never looks valid
    task automatic send(input logic [7:0] op, input logic [7:0] ct,
                        input logic [31:0] val, input logic dir);
        @(posedge i_clk);
        #1;
        o_cmd_valid = 1'b1;
        o_cmd       = {op, ct, 8'h00, val, dir};
        @(posedge i_clk);
        #1;
        o_cmd_valid = 1'b0;
        o_cmd       = ~o_cmd;
        repeat (3) @(posedge i_clk);
        #2;
    endtask

    // mask always 1 on a single motor
    task automatic event_req(input logic [7:0] ct, input logic dir);
        send(OP_EVENT_REQ, ct, 32'h0000_0001, dir);
    endtask

    // key given only when asked; missing reply is tolerated
    task automatic keyed(input logic [7:0] op, input logic good);
        send(op, 8'h00, good ? MAGIC_KEY : 32'h0000_0000, 1'b1);
    endtask
endmodule

// >>> sim/test_motion_module_control_commands.sv
`timescale 1ns/1ps
module test_motion_module_control_commands;
    import mmc_pkg::*;

    logic                i_clk;
    logic                i_rstn;
    logic                i_cmd_valid;
    mmc_cmd_t            i_cmd;
    logic                i_pos_reached;
    logic                i_prog_done;
    logic [31:0]         i_accu;
    logic [31:0]         i_xreg;
    logic                i_wait_flag;
    logic                o_reply_valid;
    mmc_reply_t          o_reply;
    logic [7:0]          o_reply_sum;
    logic                o_exec_valid;
    mmc_instr_t          o_exec;
    logic                o_prog_run;
    logic                o_prog_step;
    logic [PC_W-1:0]     o_pc;
    logic                o_prog_clear;
    logic                o_factory;
    logic                o_sw_reset;
    logic                o_dl_mode;
    int                  fail_count;
    int                  checks_done;
    int                  rep_cnt;
    int                  exec_cnt;
    int                  fac_cnt;
    int                  swr_cnt;
    int                  clr_cnt;
    int                  b;
    int                  e;
    mmc_reply_t          last_rep;
    logic [7:0]          last_sum;
    mmc_instr_t          last_exec;

    mmc_host_model host (.i_clk(i_clk), .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd));

    mmc_ctrl dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
        .i_pos_reached(i_pos_reached), .i_prog_done(i_prog_done), .i_accu(i_accu),
        .i_xreg(i_xreg), .i_wait_flag(i_wait_flag), .o_reply_valid(o_reply_valid),
        .o_reply(o_reply), .o_reply_sum(o_reply_sum), .o_exec_valid(o_exec_valid),
        .o_exec(o_exec), .o_prog_run(o_prog_run), .o_prog_step(o_prog_step), .o_pc(o_pc),
        .o_prog_clear(o_prog_clear), .o_factory(o_factory), .o_sw_reset(o_sw_reset),
        .o_dl_mode(o_dl_mode));

    always #20 i_clk = ~i_clk;

    // counts pulses and keeps the latest reply
    always @(posedge i_clk)
    begin
        if (o_reply_valid === 1'b1)
        begin
            rep_cnt++;
            last_rep = o_reply;
            last_sum = o_reply_sum;
        end
        if (o_exec_valid === 1'b1)
        begin
            exec_cnt++;
            last_exec = o_exec;
        end
        if (o_factory === 1'b1) fac_cnt++;
        if (o_sw_reset === 1'b1) swr_cnt++;
        if (o_prog_clear === 1'b1) clr_cnt++;
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one new reply since b, with fields and sum as expected
    task automatic chk_rep(input logic [7:0] st, input logic [7:0] cm, input logic [31:0] v);
        logic [7:0]  s;
        logic [87:0] got;
        logic [87:0] exp;
        s   = 8'h03 + st + cm + v[31:24] + v[23:16] + v[15:8] + v[7:0];
        got = {32'(rep_cnt - b), last_rep, last_sum};
        exp = {32'h0000_0001, st, cm, v, s};
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
        b = rep_cnt;
    endtask

    task automatic pulse(input logic done);
        @(posedge i_clk);
        #1;
        if (done) i_prog_done = 1'b1;
        else i_pos_reached = 1'b1;
        @(posedge i_clk);
        #1;
        i_prog_done   = 1'b0;
        i_pos_reached = 1'b0;
        repeat (3) @(posedge i_clk);
        #2;
    endtask

    task automatic move_and_arrive();
        host.send(OP_MOVE_TO_POS, 8'h00, 32'h0000_0100, 1'b1);
        b = rep_cnt;
        pulse(1'b0);
    endtask

    task automatic t_direct_only();
        e = exec_cnt;
        b = rep_cnt;
        host.event_req(TYPE_PERSIST, 1'b0);
        host.send(OP_RUN_APP, 8'h01, 32'h0000_0005, 1'b0);
        chk(32'(rep_cnt - b), 32'h0000_0000);
        move_and_arrive();
        chk(32'(rep_cnt - b), 32'h0000_0000);
        chk(32'(o_prog_run), 32'h0000_0000);
        chk(32'(exec_cnt - e), 32'h0000_0001);
    endtask

    task automatic t_event_once();
        b = rep_cnt;
        host.event_req(TYPE_ONCE, 1'b1);
        chk_rep(ST_OK, OP_EVENT_REQ, 32'h0000_0001);
        move_and_arrive();
        chk_rep(ST_POS_REACHED, OP_EVENT_REQ, 32'h0000_0001);
        move_and_arrive();
        chk(32'(rep_cnt - b), 32'h0000_0000);
    endtask

    task automatic t_event_persist();
        b = rep_cnt;
        host.event_req(TYPE_PERSIST, 1'b1);
        chk_rep(ST_OK, OP_EVENT_REQ, 32'h0000_0001);
        repeat (2)
        begin
            move_and_arrive();
            chk_rep(ST_POS_REACHED, OP_EVENT_REQ, 32'h0000_0001);
        end
    endtask

    task automatic t_run_stop();
        host.send(OP_RUN_APP, 8'h01, 32'h0000_0005, 1'b1);
        chk(32'(o_prog_run), 32'h0000_0001);
        chk(32'(o_pc), 32'h0000_0005);
        host.send(OP_STOP_APP, 8'h5A, 32'hFFFF_FFFF, 1'b1);
        chk(32'(o_prog_run), 32'h0000_0000);
        host.send(OP_RUN_APP, 8'h00, 32'h0000_0077, 1'b1);
        chk(32'(o_prog_run), 32'h0000_0001);
        chk(32'(o_pc), 32'h0000_0005);
        e = clr_cnt;
        host.send(OP_RESET_APP, 8'h00, 32'h0000_0000, 1'b1);
        chk(32'(o_prog_run), 32'h0000_0000);
        chk(32'(o_pc), 32'h0000_0000);
        chk(32'(clr_cnt - e), 32'h0000_0001);
        host.send(OP_STEP_APP, 8'h00, 32'h0000_0000, 1'b1);
        chk(32'(o_prog_step), 32'h0000_0001);
        pulse(1'b1);
        chk(32'(o_prog_step), 32'h0000_0000);
        chk(32'(o_prog_run), 32'h0000_0000);
    endtask

    task automatic t_status();
        host.send(OP_RESET_APP, 8'h00, 32'h0000_0000, 1'b1);
        host.send(OP_GET_STATUS, 8'h01, 32'h0000_0000, 1'b1);
        chk(last_rep.value, {MODE_IDLE, 7'h00, 1'b1, 6'h00, 10'h000});
        host.send(OP_GET_STATUS, 8'h02, 32'h0000_0000, 1'b1);
        chk(last_rep.value, i_accu);
        host.send(OP_GET_STATUS, 8'h03, 32'h0000_0000, 1'b1);
        chk(last_rep.value, i_xreg);
        host.send(OP_GET_VERSION, 8'h00, 32'h0000_0000, 1'b1);
        chk(last_rep.value, VERSION_STR);
        b = rep_cnt;
        host.send(OP_GET_VERSION, 8'h01, 32'h0000_0000, 1'b1);
        chk_rep(ST_OK, OP_GET_VERSION, VERSION_BIN);
    endtask

    task automatic t_download();
        host.send(OP_ENTER_DL, 8'h00, 32'h0000_0003, 1'b1);
        chk(32'(o_dl_mode), 32'h0000_0001);
        e = exec_cnt;
        host.send(8'h05, 8'h02, 32'h0000_00AB, 1'b1);
        chk(32'(exec_cnt - e), 32'h0000_0000);
        host.send(OP_GET_STATUS, 8'h00, 32'h0000_0000, 1'b1);
        chk(last_rep.value, {MODE_DL, 7'h00, 1'b1, 6'h00, 10'h004});
        host.send(OP_EXIT_DL, 8'h00, 32'h0000_0000, 1'b1);
        chk(32'(o_dl_mode), 32'h0000_0000);
        b = rep_cnt;
        host.send(OP_READ_MEM, 8'h00, 32'h0000_0003, 1'b1);
        chk(32'(rep_cnt - b), 32'h0000_0001);
        chk(last_rep.value, 32'h0502_00AB);
        e = exec_cnt;
        host.send(8'h05, 8'h02, 32'h0000_00AB, 1'b1);
        chk(32'(exec_cnt - e), 32'h0000_0001);
        chk({last_exec.opcode, last_exec.ctype, last_exec.value[15:0]}, 32'h0502_00AB);
    endtask

    task automatic t_keyed();
        e = fac_cnt;
        b = rep_cnt;
        host.keyed(OP_FACTORY, 1'b0);
        chk(32'(fac_cnt - e), 32'h0000_0000);
        host.keyed(OP_FACTORY, 1'b1);
        chk(32'(fac_cnt - e), 32'h0000_0001);
        chk(32'(rep_cnt - b), 32'h0000_0000);
        e = swr_cnt;
        host.keyed(OP_SW_RESET, 1'b0);
        chk(32'(swr_cnt - e), 32'h0000_0000);
        host.keyed(OP_SW_RESET, 1'b1);
        chk(32'(swr_cnt - e), 32'h0000_0001);
    endtask

    initial
    begin
        #(40 * 5000);
        fail_count++;
        give_verdict();
    end

    initial
    begin
        i_clk         = 1'b0;
        i_rstn        = 1'b0;
        i_pos_reached = 1'b0;
        i_prog_done   = 1'b0;
        i_accu        = 32'h1234_5678;
        i_xreg        = 32'h9ABC_DEF0;
        i_wait_flag   = 1'b1;
        last_rep      = '0;
        last_sum      = 8'h00;
        last_exec     = '0;
        repeat (10) @(posedge i_clk);
        #1;
        i_rstn = 1'b1;
        t_direct_only();
        t_event_once();
        t_event_persist();
        t_run_stop();
        t_status();
        t_download();
        t_keyed();
        give_verdict();
    end
endmodule
